// file: verilog/dds_chirp_bpsk_control.sv
// Notes on behaviour
// (R1) Host loads the 48-bit start word into bytes 04h to 09h.
// (R2) Signed 48-bit step word at 10h to 15h is added each ramp tick.
// (R3) 20-bit ramp dwell count lives in bytes 1Ah to 1Ch.
// (R4) Written values act only after an update pulse; upd_period and the internal-update bit act straight from the buffer.
// (R5) Step MSB set sweeps downward, clear sweeps upward.
// (R6) Chirp has no return to start and no end limit.
// (R7) Chirp keeps stepping until the host stops it.
// (R8) Sweep-clear bit clears sweep accumulator for one clock; step word kept.
// (R9) Held sweep-clear bit repeats the one-clock clear on every update edge.
// (R10) After the clear, frequency restarts at start word, same rate and direction.
// (R11) All-clear bit at 1Fh holds both accumulators at zero, 0 Hz.
// (R12) Registers may be rewritten under all-clear; new values used next sweep.
// (R13) Freeze input in chirp mode stops the ramp counter; frequency holds.
// (R14) Releasing freeze resumes the sweep from the held frequency.
// (R15) New ramp count loads only after the running countdown reaches zero.
// (R16) Host finishes rewrites before the next internal update pulse.
// (R17) All-zero step word holds the present frequency.
// (R18) Host may end a sweep by freezing then ramping amplitude down.
// (R19) Host may use periodic updates with sweep-clear for sawtooth sweeps.
// (R20) Phase-key mode: key input low picks offset one, high picks two.
// (R21) Host sets carrier, both phase words, data source, then updates.
// (R22) Higher-order keying: host rewrites offset one in single-tone mode.
// (R23) Ramp counter counts down, pulses at zero, each pulse steps once.
// (R24) Start word plus sweep accumulator feeds the 48-bit phase accumulator.
// (R25) Writes go to buffers, copied to core on update rising edge.
// (R26) Mode bit picks chirp or phase keying; key input meaning follows mode; key input also picks the phase offset in chirp mode.
module dds_chirp_bpsk_control
    import dds_chirp_pkg::*;
(
    // clock and reset
    input  wire logic                            clk,
    input  wire logic                            srst,
    // parallel programming port
    input  wire logic [dds_chirp_pkg::ADDR_W-1:0] bus_addr,
    input  wire logic [dds_chirp_pkg::DATA_W-1:0] bus_wdata,
    input  wire logic                            bus_wr,
    input  wire logic                            bus_rd,
    output logic      [dds_chirp_pkg::DATA_W-1:0] bus_rdata,
    // update and keying pins
    input  wire logic                            ext_update,
    input  wire logic                            key_in,
    output logic                                 update_pulse,
    // synthesizer core outputs
    output logic      [dds_chirp_pkg::FREQ_W-1:0] freq_word,
    output logic      [dds_chirp_pkg::FREQ_W-1:0] phase_word
);
    import dds_chirp_pkg::*;

    // ****************************************
    // pin synchronisers
    // ****************************************
    localparam int PIN_W = ADDR_W + DATA_W + 4;

    logic [PIN_W-1:0]  pins_sync;
    logic [ADDR_W-1:0] addr_s;
    logic [DATA_W-1:0] wdata_s;
    logic              wr_s;
    logic              rd_s;
    logic              upd_s;
    logic              key_s;

    sync2 #(
        .W (PIN_W)
    ) u_pin_sync (
        .clk  (clk),
        .srst (srst),
        .d    ({bus_addr, bus_wdata, bus_wr, bus_rd, ext_update, key_in}),
        .q    (pins_sync)
    );

    assign {addr_s, wdata_s, wr_s, rd_s, upd_s, key_s} = pins_sync;

    // ****************************************
    // state
    // ****************************************
    // buffer side, written by the host
    logic [FREQ_W-1:0]      start_buf;
    logic [FREQ_W-1:0]      step_buf;
    logic [UPD_W-1:0]       upd_period;
    logic [TICK_BYTES*8-1:0] tick_buf;
    logic [DATA_W-1:0]      ctrl_buf;
    logic [2*DATA_W-1:0]    phase1_buf;
    logic [2*DATA_W-1:0]    phase2_buf;
    // active core copy
    logic [FREQ_W-1:0]      start_tuning_word;
    logic [FREQ_W-1:0]      sweep_step_word;
    logic [TICK_W-1:0]      sweep_tick_count;
    logic [DATA_W-1:0]      accum_clear_control;
    logic [PHASE_OFS_W-1:0] phase1_ofs;
    logic [PHASE_OFS_W-1:0] phase2_ofs;
    // edges, timers, accumulators
    logic                   wr_d;
    logic                   rd_d;
    logic                   upd_d;
    logic [UPD_W-1:0]       upd_count;
    logic                   sweep_clr_pulse;
    logic [FREQ_W-1:0]      sweep_accumulator;
    logic [FREQ_W-1:0]      phase_accumulator;

    logic [FREQ_W-1:0]      next_start_buf;
    logic [FREQ_W-1:0]      next_step_buf;
    logic [UPD_W-1:0]       next_upd_period;
    logic [TICK_BYTES*8-1:0] next_tick_buf;
    logic [DATA_W-1:0]      next_ctrl_buf;
    logic [2*DATA_W-1:0]    next_phase1_buf;
    logic [2*DATA_W-1:0]    next_phase2_buf;
    logic [FREQ_W-1:0]      next_start_tuning_word;
    logic [FREQ_W-1:0]      next_sweep_step_word;
    logic [TICK_W-1:0]      next_sweep_tick_count;
    logic [DATA_W-1:0]      next_accum_clear_control;
    logic [PHASE_OFS_W-1:0] next_phase1_ofs;
    logic [PHASE_OFS_W-1:0] next_phase2_ofs;
    logic [UPD_W-1:0]       next_upd_count;
    logic                   next_update_pulse;
    logic                   next_sweep_clr_pulse;
    logic [FREQ_W-1:0]      next_sweep_accumulator;
    logic [FREQ_W-1:0]      next_phase_accumulator;
    logic [FREQ_W-1:0]      next_freq_word;
    logic [FREQ_W-1:0]      next_phase_word;
    logic [DATA_W-1:0]      next_bus_rdata;

    // ****************************************
    // decoded control
    // ****************************************
    mode_t             mode;
    logic              all_clear;
    logic              freeze;
    logic              ramp_run;
    logic              ramp_tick;
    logic              wr_evt;
    logic              rd_evt;
    logic              ext_upd_evt;
    logic              int_upd_evt;
    logic              upd_evt;
    logic [PHASE_OFS_W-1:0] sel_ofs;

    assign mode      = mode_t'(accum_clear_control[CTRL_MODE_BIT]);        // [R26]
    assign all_clear = accum_clear_control[CTRL_ALL_CLR_BIT];
    // key input doubles as freeze only in chirp mode
    assign freeze    = (mode == MODE_CHIRP) && key_s;                       // [R13] [R26]
    assign ramp_run  = (mode == MODE_CHIRP) && !freeze && !all_clear;       // [R14]
    assign sel_ofs   = key_s ? phase2_ofs : phase1_ofs;                     // [R20]

    assign wr_evt      = wr_s && !wr_d;
    assign rd_evt      = rd_s && !rd_d;
    assign ext_upd_evt = upd_s && !upd_d;                                   // [R25]
    assign int_upd_evt = ctrl_buf[CTRL_INT_UPD_BIT] && (upd_count == '0);
    assign upd_evt     = ext_upd_evt || int_upd_evt;

    // ****************************************
    // ramp rate counter
    // ****************************************
    sweep_tick_counter #(
        .W (TICK_W)
    ) u_ramp (
        .clk        (clk),
        .srst       (srst),
        .load_value (sweep_tick_count),                                     // [R3]
        .run        (ramp_run),                                             // [R13]
        .tick       (ramp_tick)
    );

    // ****************************************
    // register port and update transfer
    // ****************************************
    always_comb begin
        next_start_buf  = start_buf;
        next_step_buf   = step_buf;
        next_upd_period = upd_period;
        next_tick_buf   = tick_buf;
        next_ctrl_buf   = ctrl_buf;
        next_phase1_buf = phase1_buf;
        next_phase2_buf = phase2_buf;
        next_bus_rdata  = bus_rdata;

        // writes land in buffers; core copies at update
        if (wr_evt) begin
            for (int i = 0; i < FREQ_BYTES; i++) begin
                if (addr_s == ADDR_START_MSB + 6'(i)) begin
                    next_start_buf[(FREQ_BYTES-1-i)*8 +: 8] = wdata_s;      // [R1] [R25] [R12]
                end
                if (addr_s == ADDR_STEP_MSB + 6'(i)) begin
                    next_step_buf[(FREQ_BYTES-1-i)*8 +: 8] = wdata_s;       // [R2] [R25]
                end
            end
            for (int i = 0; i < UPD_BYTES; i++) begin
                if (addr_s == ADDR_UPD_MSB + 6'(i)) begin
                    next_upd_period[(UPD_BYTES-1-i)*8 +: 8] = wdata_s;
                end
            end
            for (int i = 0; i < TICK_BYTES; i++) begin
                if (addr_s == ADDR_TICK_MSB + 6'(i)) begin
                    next_tick_buf[(TICK_BYTES-1-i)*8 +: 8] = wdata_s;       // [R3]
                end
            end
            // unused dwell-count top reads zero
            next_tick_buf[TICK_BYTES*8-1 -: 8] = next_tick_buf[TICK_BYTES*8-1 -: 8]
                                                 & TICK_TOP_MASK;
            if (addr_s == ADDR_CTRL) begin
                next_ctrl_buf = wdata_s & CTRL_MASK;
            end
            if (addr_s == ADDR_PHASE1_HI) begin
                next_phase1_buf[15:8] = wdata_s & PHASE_HI_MASK;
            end
            if (addr_s == ADDR_PHASE1_LO) begin
                next_phase1_buf[7:0] = wdata_s;
            end
            if (addr_s == ADDR_PHASE2_HI) begin
                next_phase2_buf[15:8] = wdata_s & PHASE_HI_MASK;
            end
            if (addr_s == ADDR_PHASE2_LO) begin
                next_phase2_buf[7:0] = wdata_s;
            end
        end

        // reads: buffers plus live frequency
        if (rd_evt) begin
            next_bus_rdata = UNMAPPED_READ;
            for (int i = 0; i < FREQ_BYTES; i++) begin
                if (addr_s == ADDR_START_MSB + 6'(i)) begin
                    next_bus_rdata = start_buf[(FREQ_BYTES-1-i)*8 +: 8];
                end
                if (addr_s == ADDR_STEP_MSB + 6'(i)) begin
                    next_bus_rdata = step_buf[(FREQ_BYTES-1-i)*8 +: 8];
                end
                if (addr_s == ADDR_FREQ_MSB + 6'(i)) begin
                    next_bus_rdata = freq_word[(FREQ_BYTES-1-i)*8 +: 8];
                end
            end
            for (int i = 0; i < UPD_BYTES; i++) begin
                if (addr_s == ADDR_UPD_MSB + 6'(i)) begin
                    next_bus_rdata = upd_period[(UPD_BYTES-1-i)*8 +: 8];
                end
            end
            for (int i = 0; i < TICK_BYTES; i++) begin
                if (addr_s == ADDR_TICK_MSB + 6'(i)) begin
                    next_bus_rdata = tick_buf[(TICK_BYTES-1-i)*8 +: 8];
                end
            end
            if (addr_s == ADDR_CTRL) begin
                next_bus_rdata = ctrl_buf;
            end
            if (addr_s == ADDR_PHASE1_HI) begin
                next_bus_rdata = phase1_buf[15:8];
            end
            if (addr_s == ADDR_PHASE1_LO) begin
                next_bus_rdata = phase1_buf[7:0];
            end
            if (addr_s == ADDR_PHASE2_HI) begin
                next_bus_rdata = phase2_buf[15:8];
            end
            if (addr_s == ADDR_PHASE2_LO) begin
                next_bus_rdata = phase2_buf[7:0];
            end
        end
    end

    always_comb begin
        next_start_tuning_word   = start_tuning_word;
        next_sweep_step_word     = sweep_step_word;
        next_sweep_tick_count    = sweep_tick_count;
        next_accum_clear_control = accum_clear_control;
        next_phase1_ofs          = phase1_ofs;
        next_phase2_ofs          = phase2_ofs;
        next_upd_count           = upd_count;
        next_update_pulse        = upd_evt;
        next_sweep_clr_pulse     = 1'b0;

        // internal periodic update: one event every period+1 clocks
        if (!ctrl_buf[CTRL_INT_UPD_BIT] || upd_count == '0) begin
            next_upd_count = upd_period;
        end else begin
            next_upd_count = upd_count - 1'b1;
        end

        if (upd_evt) begin
            next_start_tuning_word   = start_buf;                           // [R4] [R25]
            next_sweep_step_word     = step_buf;                            // [R4] [R25]
            next_sweep_tick_count    = tick_buf[TICK_W-1:0];                // [R4] [R25]
            next_accum_clear_control = ctrl_buf;                            // [R4] [R25]
            next_phase1_ofs          = phase1_buf[PHASE_OFS_W-1:0];
            next_phase2_ofs          = phase2_buf[PHASE_OFS_W-1:0];
            // one clear clock per update while set
            next_sweep_clr_pulse     = ctrl_buf[CTRL_SWEEP_CLR_BIT];        // [R8] [R9]
        end
    end

    // ****************************************
    // accumulators
    // ****************************************
    always_comb begin
        next_sweep_accumulator = sweep_accumulator;
        next_phase_accumulator = phase_accumulator + freq_word;             // [R24]
        // no limit check: sum wraps
        if (all_clear || mode == MODE_PHASE_KEY) begin
            next_sweep_accumulator = '0;                                    // [R11]
        end else if (sweep_clr_pulse) begin
            next_sweep_accumulator = '0;                                    // [R8] [R10]
        end else if (ramp_tick) begin
            // signed add: set MSB steps down, zero step holds
            next_sweep_accumulator = sweep_accumulator + sweep_step_word;   // [R5] [R6] [R7] [R17]
        end
        if (all_clear) begin
            next_phase_accumulator = '0;                                    // [R11]
        end
        next_freq_word  = start_tuning_word + next_sweep_accumulator;       // [R24] [R10]
        next_phase_word = phase_accumulator
                          + {sel_ofs, {(FREQ_W-PHASE_OFS_W){1'b0}}};        // [R20]
        if (all_clear) begin
            next_freq_word = '0;                                            // [R11]
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            start_buf           <= '0;
            step_buf            <= '0;
            upd_period          <= '0;
            tick_buf            <= '0;
            ctrl_buf            <= CTRL_RESET;
            phase1_buf          <= '0;
            phase2_buf          <= '0;
            start_tuning_word   <= '0;
            sweep_step_word     <= '0;
            sweep_tick_count    <= '0;
            accum_clear_control <= CTRL_RESET;
            phase1_ofs          <= '0;
            phase2_ofs          <= '0;
            wr_d                <= 1'b0;
            rd_d                <= 1'b0;
            upd_d               <= 1'b0;
            upd_count           <= '0;
            update_pulse        <= 1'b0;
            sweep_clr_pulse     <= 1'b0;
            sweep_accumulator   <= '0;
            phase_accumulator   <= '0;
            freq_word           <= '0;
            phase_word          <= '0;
            bus_rdata           <= '0;
        end else begin
            start_buf           <= next_start_buf;
            step_buf            <= next_step_buf;
            upd_period          <= next_upd_period;
            tick_buf            <= next_tick_buf;
            ctrl_buf            <= next_ctrl_buf;
            phase1_buf          <= next_phase1_buf;
            phase2_buf          <= next_phase2_buf;
            start_tuning_word   <= next_start_tuning_word;
            sweep_step_word     <= next_sweep_step_word;
            sweep_tick_count    <= next_sweep_tick_count;
            accum_clear_control <= next_accum_clear_control;
            phase1_ofs          <= next_phase1_ofs;
            phase2_ofs          <= next_phase2_ofs;
            wr_d                <= wr_s;
            rd_d                <= rd_s;
            upd_d               <= upd_s;
            upd_count           <= next_upd_count;
            update_pulse        <= next_update_pulse;
            sweep_clr_pulse     <= next_sweep_clr_pulse;
            sweep_accumulator   <= next_sweep_accumulator;
            phase_accumulator   <= next_phase_accumulator;
            freq_word           <= next_freq_word;
            phase_word          <= next_phase_word;
            bus_rdata           <= next_bus_rdata;
        end
    end

endmodule

// file: verilog/dds_chirp_pkg.sv
package dds_chirp_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int FREQ_W      = 48;
    localparam int TICK_W      = 20;
    localparam int PHASE_OFS_W = 14;
    localparam int UPD_W       = 32;
    localparam int ADDR_W      = 6;
    localparam int DATA_W      = 8;

    // ****************************************
    // byte addresses of the parallel port
    // ****************************************
    localparam logic [ADDR_W-1:0] ADDR_PHASE1_HI  = 6'h00;
    localparam logic [ADDR_W-1:0] ADDR_PHASE1_LO  = 6'h01;
    localparam logic [ADDR_W-1:0] ADDR_PHASE2_HI  = 6'h02;
    localparam logic [ADDR_W-1:0] ADDR_PHASE2_LO  = 6'h03;
    localparam logic [ADDR_W-1:0] ADDR_START_MSB  = 6'h04;
    localparam logic [ADDR_W-1:0] ADDR_STEP_MSB   = 6'h10;
    localparam logic [ADDR_W-1:0] ADDR_UPD_MSB    = 6'h16;
    localparam logic [ADDR_W-1:0] ADDR_TICK_MSB   = 6'h1A;
    localparam logic [ADDR_W-1:0] ADDR_CTRL       = 6'h1F;
    localparam logic [ADDR_W-1:0] ADDR_FREQ_MSB   = 6'h30;

    // byte counts of the multi-byte words
    localparam int FREQ_BYTES = 6;
    localparam int UPD_BYTES  = 4;
    localparam int TICK_BYTES = 3;

    // ****************************************
    // control byte layout and reset values
    // ****************************************
    localparam int CTRL_MODE_BIT      = 0;
    localparam int CTRL_SWEEP_CLR_BIT = 2;
    localparam int CTRL_ALL_CLR_BIT   = 3;
    localparam int CTRL_INT_UPD_BIT   = 4;

    localparam logic [DATA_W-1:0] CTRL_RESET     = 8'h00;
    localparam logic [DATA_W-1:0] CTRL_MASK      = 8'h1D;
    localparam logic [DATA_W-1:0] TICK_TOP_MASK  = 8'h0F;
    localparam logic [DATA_W-1:0] PHASE_HI_MASK  = 8'h3F;
    localparam logic [DATA_W-1:0] UNMAPPED_READ  = 8'h00;

    typedef enum logic {
        MODE_CHIRP,
        MODE_PHASE_KEY
    } mode_t;

endpackage

// file: verilog/sync2.sv
module sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         srst,
    // asynchronous in, synchronous out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge clk) begin
        if (srst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

// file: verilog/sweep_tick_counter.sv
module sweep_tick_counter #(
    parameter int W = 20
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         srst,
    // reload value and run gate
    input  wire logic [W-1:0] load_value,
    input  wire logic         run,
    // one pulse per expiry
    output logic              tick
);

    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic         next_tick;

    // run low stands in for a gated clock
    always_comb begin
        next_count = count;
        next_tick  = 1'b0;
        if (run) begin
            if (count == '0) begin
                next_tick  = 1'b1;       // [R23]
                next_count = load_value; // [R15]
            end else begin
                next_count = count - 1'b1; // [R23]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            count <= '0;
            tick  <= 1'b0;
        end else begin
            count <= next_count;
            tick  <= next_tick;
        end
    end

endmodule

// file: bench/dds_chirp_checker_assertions.sv
module dds_chirp_checker
    import dds_chirp_pkg::*;
(
    // clock and reset
    input wire logic                             clk,
    input wire logic                             srst,
    // watched ports
    input wire logic                             bus_rd,
    input wire logic [dds_chirp_pkg::DATA_W-1:0] bus_rdata,
    input wire logic                             ext_update,
    input wire logic                             key_in,
    input wire logic                             update_pulse,
    input wire logic [dds_chirp_pkg::FREQ_W-1:0] freq_word,
    input wire logic [dds_chirp_pkg::FREQ_W-1:0] phase_word
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // ****
    // assertions
    // ****
    // quiet window lets pipelines settle
    a_reset_outs: assert property ($fell(srst) |-> !update_pulse && freq_word == '0
        && phase_word == '0 && bus_rdata == '0) else $error("outputs not clear after reset");
    a_pulse_narrow: assert property (update_pulse |=> !update_pulse)
        else $error("update pulse longer than one cycle");
    a_upd_latency: assert property ($rose(ext_update) |-> !update_pulse ##1
        !update_pulse ##[1:3] update_pulse) else $error("update pulse late or early");
    a_upd_cause: assert property ($rose(update_pulse) |-> $past(ext_update, 2))
        else $error("update pulse without update pin");
    a_rdata_cause: assert property ($changed(bus_rdata) |-> $past(bus_rd, 3))
        else $error("read data moved without read");
    a_rdata_hold: assert property ((!bus_rd) [*6] |=> $stable(bus_rdata))
        else $error("read data not held");
    a_rd_wait: assert property ($rose(bus_rd) |-> $stable(bus_rdata) [*2])
        else $error("read data too early");
    a_phase_step: assert property (($stable(freq_word) && $stable(key_in) && !update_pulse) [*7]
        |-> phase_word ==
        FREQ_W'($past(phase_word) + $past(freq_word))) else $error("phase step wrong");
    c_update: cover property (update_pulse);
    c_read: cover property ($changed(bus_rdata));
    c_step: cover property ($changed(freq_word) && !update_pulse);
endmodule
bind dds_chirp_bpsk_control dds_chirp_checker i_chk (
    .clk, .srst, .bus_rd, .bus_rdata, .ext_update, .key_in, .update_pulse, .freq_word,
    .phase_word
);

// file: bench/host_model.sv
module host_model
    import dds_chirp_pkg::*;
(
    // clock
    input wire logic                             clk,
    // register port and pins
    output logic     [dds_chirp_pkg::ADDR_W-1:0] bus_addr,
    output logic     [dds_chirp_pkg::DATA_W-1:0] bus_wdata,
    output logic                                 bus_wr,
    output logic                                 bus_rd,
    input wire logic [dds_chirp_pkg::DATA_W-1:0] bus_rdata,
    output logic                                 ext_update,
    output logic                                 key_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {bus_addr, bus_wdata, bus_wr, bus_rd, ext_update, key_in} = '0;
    // strobes pass two sync flops
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        {bus_addr, bus_wdata, bus_wr} = {a, d, 1'b1};
        repeat (6) @(negedge clk);
        bus_wr = 1'b0;
        repeat (4) @(negedge clk);
        bus_wdata = ~d;
    endtask
    // top byte at the lowest address
    task automatic w48(input logic [ADDR_W-1:0] a, input logic [47:0] v);
        for (int i = 0; i < 6; i++) wr(ADDR_W'(a + i), v[8*(5-i) +: 8]);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        {bus_addr, bus_rd} = {a, 1'b1};
        repeat (6) @(negedge clk);
        d = bus_rdata;
        bus_rd = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    // after all writes
    task automatic upd();
        ext_update = 1'b1;
        repeat (4) @(negedge clk);
        ext_update = 1'b0;
        repeat (4) @(negedge clk);
    endtask
endmodule

// file: bench/tb_top.sv
module tb_top import dds_chirp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk, srst, bus_wr, bus_rd, ext_update, key_in, update_pulse;
    logic [ADDR_W-1:0] bus_addr;
    logic [DATA_W-1:0] bus_wdata, bus_rdata, rb;
    logic [FREQ_W-1:0] freq_word, phase_word, s, d;
    logic [31:0]       p;
    int                failures = 0, cmp_count = 0;
    host_model i_host (.clk, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
        .ext_update, .key_in);
    dds_chirp_bpsk_control i_dut (.clk, .srst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
        .bus_rdata, .ext_update, .key_in, .update_pulse, .freq_word, .phase_word);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic end_of_test();
        if (failures == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [FREQ_W-1:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        i_host.rd(a, rb);
        chk("bus_rdata", FREQ_W'(e), FREQ_W'(rb));
    endtask
    task automatic set_tick(input logic [19:0] v);
        for (int i = 0; i < 3; i++) i_host.wr(ADDR_TICK_MSB + 6'(i), 8'({4'hF, v} >> 8 * (2 - i)));
    endtask
    // returns at the pulse; host tail runs on
    task automatic go();
        int t;
        fork
            i_host.upd();
        join_none
        for (t = 0; t < 9 && update_pulse !== 1'b1; t++) @(negedge clk);
        chk("update_pulse", FREQ_W'(1), FREQ_W'(t < 9));
        if (t == 9) end_of_test();
    endtask
    task automatic wait_val(input logic [FREQ_W-1:0] v);
        int t;
        for (t = 0; t < 8 && freq_word !== v; t++) @(negedge clk);
        chk("freq_word", v, freq_word);
        if (t == 8) end_of_test();
    endtask
    // each change one step; spacing from the 2nd change
    task automatic watch(input int cnt, per, lim, input logic [FREQ_W-1:0] stp);
        logic [FREQ_W-1:0] prev;
        int                k, t, last;
        prev = freq_word;
        k = 0;
        last = -1;
        for (t = 0; t < lim && (k < cnt || cnt == 0); t++) begin
            @(negedge clk);
            if (freq_word !== prev) begin
                chk("freq_step", prev + stp, freq_word);
                if (last >= 0) chk("tick_period", FREQ_W'(per), FREQ_W'(t - last));
                last = t;
                prev = freq_word;
                k++;
            end
        end
        chk("step_count", FREQ_W'(cnt), FREQ_W'(k));
        if (k < cnt) end_of_test();
    endtask
    initial begin
        srst = 1'b1;
        void'($urandom(32'h75CD8DE2));
        s = {16'h0000, $urandom()};
        d = {28'h0000000, 20'($urandom())} | 48'h1;
        p = $urandom();
        repeat (20) @(negedge clk);
        srst = 1'b0;
        rchk(ADDR_CTRL, CTRL_RESET);
        i_host.wr(ADDR_CTRL, 8'hE6);
        rchk(ADDR_CTRL, 8'h04);
        rchk(6'h3F, UNMAPPED_READ);
        i_host.w48(ADDR_START_MSB, s);
        i_host.w48(ADDR_STEP_MSB, d);
        set_tick(20'h0000C);
        rchk(ADDR_START_MSB, s[47:40]);
        rchk(ADDR_TICK_MSB, 8'h00);
        chk("freq_word", '0, freq_word);
        go();
        wait_val(s);
        watch(3, 13, 80, d);
        go();
        wait_val(s);
        watch(2, 13, 60, d);
        go();
        wait_val(s);
        i_host.wr(ADDR_CTRL, 8'h00);
        i_host.key_in = 1'b1;
        repeat (4) @(negedge clk);
        watch(0, 1, 60, '0);
        set_tick(20'h00004);
        go();
        watch(0, 1, 30, '0);
        i_host.key_in = 1'b0;
        watch(3, 5, 60, d);
        i_host.w48(ADDR_STEP_MSB, -d);
        go();
        watch(3, 5, 40, -d);
        i_host.w48(ADDR_STEP_MSB, '0);
        go();
        repeat (8) @(negedge clk);
        watch(0, 1, 50, '0);
        i_host.wr(ADDR_CTRL, 8'h08);
        go();
        wait_val('0);
        i_host.w48(ADDR_START_MSB, ~s);
        chk("phase_word", '0, phase_word);
        i_host.wr(ADDR_CTRL, 8'h00);
        go();
        wait_val(~s);
        i_host.wr(ADDR_CTRL, 8'h09);
        go();
        i_host.w48(ADDR_START_MSB, '0);
        for (int i = 0; i < 4; i++) i_host.wr(ADDR_W'(i ^ 1), p[8*i +: 8]);
        i_host.wr(ADDR_CTRL, 8'h01);
        go();
        for (int k = 0; k < 2; k++) begin
            i_host.key_in = k[0];
            repeat (8) @(negedge clk);
            chk("phase_word", {(k[0] ? p[29:16] : p[13:0]), 34'h0}, phase_word);
        end
        end_of_test();
    end
endmodule
